//--- logic/nbp_pkg.sv
package nbp_pkg;
	// ****************************************
	// Address map of the port latches.
	// ****************************************
	// Address word is {bank[1:0], offset[6:0]}.
	localparam logic [1:0] BANK_0         = 2'h0;
	localparam logic [1:0] BANK_1         = 2'h1;
	localparam logic [1:0] BANK_2         = 2'h2;
	localparam logic [1:0] BANK_RF        = 2'h3;
	localparam logic [6:0] OFS_LATCH_70   = 7'h70;
	localparam logic [6:0] OFS_LATCH_71   = 7'h71;
	localparam logic [6:0] OFS_LATCH_72   = 7'h72;
	localparam logic [6:0] OFS_LATCH_73   = 7'h73;
	// ****************************************
	// Register file words.
	// ****************************************
	localparam logic [6:0] OFS_GROUP_DIR  = 7'h27;
	localparam logic [6:0] OFS_B_DIR      = 7'h36;
	localparam logic [6:0] OFS_A_DIR      = 7'h37;
	localparam logic [6:0] OFS_SYNTH_LO   = 7'h40;
	localparam logic [6:0] OFS_SYNTH_MID  = 7'h41;
	localparam logic [6:0] OFS_SYNTH_HI   = 7'h42;
	localparam logic [6:0] OFS_SYNTH_CTL  = 7'h43;
	localparam logic [6:0] OFS_DUTY_BASE  = 7'h44;
	localparam logic [6:0] OFS_DUTY_MODE  = 7'h4C;
	localparam logic [6:0] OFS_EDGE_CTL   = 7'h4D;
	localparam logic [6:0] OFS_IRQ_STAT   = 7'h4E;
	localparam logic [6:0] OFS_IRQ_MASK   = 7'h4F;
	localparam logic [6:0] OFS_ALT_CTL    = 7'h50;
	// ****************************************
	// Field positions and reset values.
	// ****************************************
	localparam int         ALT_SERIAL3    = 0;
	localparam int         ALT_SERIAL2    = 1;
	localparam int         ALT_LINECNT    = 2;
	localparam int         SYNTH_DAC_EN   = 0;
	localparam int         SYNTH_PORT_BIT = 1;
	localparam int         IRQ_REMOTE     = 0;
	localparam int         IRQ_LINECNT    = 1;
	localparam logic [3:0] RST_DIR        = 4'h0;
	localparam logic [3:0] RST_NIBBLE     = 4'h0;
	localparam logic [3:0] RST_OD_LATCH   = 4'hF;
	// ****************************************
	// Timing.
	// ****************************************
	localparam int         CLK_HZ         = 25000000;
	localparam int         DUTY_HZ        = 15625;
	localparam int         DUTY_STEPS     = 64;
	localparam int         DUTY_TICK_CYC  = CLK_HZ / (DUTY_HZ * DUTY_STEPS);
	localparam int         SYNTH_PWM_W    = 9;
	localparam int         SYNTH_RMP_W    = 5;
endpackage

//--- logic/nbp_sync.sv
`timescale 1ns/1ps
// ****************************************
// Three-stage pin synchroniser with agreement check.
// ****************************************
module nbp_sync #(
	parameter int W = 4
) (
	input  wire logic         clk,
	input  wire logic         clk_en,
	input  wire logic         sys_rst,
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] pin_sync
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] val;
	} nbp_sync_t;

	nbp_sync_t state_q;
	nbp_sync_t state_d;

	// The value only moves when stages two and three agree.
	always_comb begin
		state_d     = state_q;
		state_d.s1  = pin_in;
		state_d.s2  = state_q.s1;
		state_d.s3  = state_q.s2;
		for (int i = 0; i < W; i++) begin
			if (state_q.s2[i] == state_q.s3[i]) begin
				state_d.val[i] = state_q.s3[i];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_q <= '0;
		end else if (clk_en) begin
			state_q <= state_d;
		end
	end

	assign pin_sync = state_q.val;
endmodule // nbp_sync

//--- logic/nbp_port.sv
`timescale 1ns/1ps
module nbp_port
	import nbp_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       clk_en,
	input  wire logic       sys_rst,
	input  wire logic       ce_rst,
	input  wire logic [8:0] reg_addr,
	input  wire logic [3:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [3:0] reg_rdata,
	input  wire logic [3:0] bidir_nibble_a_in,
	output logic      [3:0] bidir_nibble_a_out,
	output logic      [3:0] bidir_nibble_a_oe,
	input  wire logic [3:0] bidir_nibble_b_in,
	output logic      [3:0] bidir_nibble_b_out,
	output logic      [3:0] bidir_nibble_b_oe,
	input  wire logic [3:0] analog_shared_nibble_in,
	output logic      [3:0] analog_shared_nibble_out,
	output logic      [3:0] analog_shared_nibble_oe,
	input  wire logic [3:0] input_nibble_d_in,
	output logic      [3:0] heavy_drive_output_nibble_oe,
	output logic      [3:0] opendrain_nibble_b_oe,
	output logic      [3:0] opendrain_nibble_c_oe,
	output logic      [3:0] pushpull_nibble_c_out,
	output logic            synth_dac_output_oe,
	output logic      [3:0] variable_duty_port_oe,
	input  wire logic       remote_event_input,
	input  wire logic       serial_data_out,
	input  wire logic       serial_clock_out,
	input  wire logic       serial_clock_oe,
	input  wire logic       twowire_data_low,
	input  wire logic       twowire_clock_low,
	output logic            serial_data_in,
	output logic            twowire_data_in,
	output logic            twowire_clock_in,
	output logic            line_count_input,
	output logic            irq
);
	// ****************************************
	// State.
	// ****************************************
	typedef struct packed {
		logic [3:0]                  a_lat;
		logic [3:0]                  b_lat;
		logic [3:0]                  pc_lat;
		logic [3:0]                  an_lat;
		logic [3:0]                  hv_lat;
		logic [3:0]                  odb_lat;
		logic [3:0]                  odc_lat;
		logic [3:0]                  a_dir;
		logic [3:0]                  b_dir;
		logic                        grp_dir;
		logic [2:0]                  alt;
		logic [SYNTH_PWM_W+SYNTH_RMP_W-1:0] synth_val;
		logic [1:0]                  synth_ctl;
		logic [3:0][5:0]             duty_val;
		logic [3:0]                  duty_mode;
		logic                        edge_sel;
		logic [1:0]                  irq_stat;
		logic [1:0]                  irq_mask;
		logic [7:0]                  tick_cnt;
		logic [5:0]                  phase;
		logic [SYNTH_PWM_W-1:0]      pwm_cnt;
		logic [SYNTH_RMP_W-1:0]      rmp_cnt;
		logic                        rem_prev;
		logic                        hs_prev;
		logic [3:0]                  rdata;
		logic [3:0]                  a_out;
		logic [3:0]                  a_oe;
		logic [3:0]                  b_out;
		logic [3:0]                  b_oe;
		logic [3:0]                  an_oe;
		logic [3:0]                  hv_oe;
		logic [3:0]                  odb_oe;
		logic [3:0]                  odc_oe;
		logic                        synth_oe;
		logic [3:0]                  duty_oe;
		logic                        sdi;
		logic                        tw_d;
		logic                        tw_c;
		logic                        hsc;
		logic                        irq;
	} nbp_port_t;

	nbp_port_t  state_q;
	nbp_port_t  state_d;
	logic [3:0] a_s;
	logic [3:0] b_s;
	logic [3:0] an_s;
	logic [3:0] d_s;
	logic [3:0] rem_s;

	nbp_sync #(.W(16)) u_sync (
		.clk      (clk),
		.clk_en   (clk_en),
		.sys_rst  (sys_rst),
		.pin_in   ({bidir_nibble_a_in, bidir_nibble_b_in,
			    analog_shared_nibble_in, input_nibble_d_in}),
		.pin_sync ({a_s, b_s, an_s, d_s})
	);
	nbp_sync #(.W(4)) u_sync_rem (
		.clk      (clk),
		.clk_en   (clk_en),
		.sys_rst  (sys_rst),
		.pin_in   ({3'h0, remote_event_input}),
		.pin_sync (rem_s)
	);

	localparam logic [7:0] TICK_LAST = 8'(DUTY_TICK_CYC - 1);

	// ****************************************
	// Next-state logic.
	// ****************************************
	always_comb begin
		logic [6:0]  ofs;
		logic [1:0]  bank;
		logic        rmp_add;
		logic        pwm_hi;
		logic        rem_edge;
		logic        hs_edge;
		logic [1:0]  ev;
		ofs      = reg_addr[6:0];
		bank     = reg_addr[8:7];
		rmp_add  = 1'b0;
		pwm_hi   = 1'b0;
		rem_edge = 1'b0;
		hs_edge  = 1'b0;
		ev       = 2'h0;
		state_d  = state_q;
		// Writes.
		if (reg_wr) begin
			if (bank == BANK_1 && ofs == OFS_LATCH_70) begin
				state_d.hv_lat = reg_wdata;
			end else if (bank == BANK_0 && ofs == OFS_LATCH_71) begin
				state_d.b_lat = reg_wdata;
			end else if (bank == BANK_0 && ofs == OFS_LATCH_70) begin
				state_d.a_lat = reg_wdata;
			end else if (bank == BANK_2 && ofs == OFS_LATCH_71) begin
				state_d.odb_lat = reg_wdata;
			end else if (bank == BANK_2 && ofs == OFS_LATCH_72) begin
				state_d.odc_lat = reg_wdata;
			end else if (bank == BANK_0 && ofs == OFS_LATCH_72) begin
				state_d.pc_lat = reg_wdata;
			end else if (bank == BANK_1 && ofs == OFS_LATCH_72) begin
				state_d.an_lat = reg_wdata;
			end else if (bank == BANK_RF && ofs == OFS_B_DIR) begin
				state_d.b_dir = reg_wdata;
			end else if (bank == BANK_RF && ofs == OFS_A_DIR) begin
				state_d.a_dir = reg_wdata;
			end else if (bank == BANK_RF && ofs == OFS_GROUP_DIR) begin
				state_d.grp_dir = reg_wdata[0];
			end else if (bank == BANK_RF && ofs == OFS_SYNTH_LO) begin
				state_d.synth_val[3:0] = reg_wdata;
			end else if (bank == BANK_RF && ofs == OFS_SYNTH_MID) begin
				state_d.synth_val[7:4] = reg_wdata;
			end else if (bank == BANK_RF && ofs == OFS_SYNTH_HI) begin
				state_d.synth_val[13:12] = reg_wdata[1:0];
			end else if (bank == BANK_RF && ofs == OFS_SYNTH_CTL) begin
				state_d.synth_ctl = reg_wdata[1:0];
			end else if (bank == BANK_RF && ofs >= OFS_DUTY_BASE
				     && ofs < OFS_DUTY_MODE) begin
				// Two words per duty channel, low nibble first.
				if (ofs[0]) begin
					state_d.duty_val[ofs[2:1] - OFS_DUTY_BASE[2:1]][5:4] = reg_wdata[1:0];
				end else begin
					state_d.duty_val[ofs[2:1] - OFS_DUTY_BASE[2:1]][3:0] = reg_wdata;
				end
			end else if (bank == BANK_RF && ofs == OFS_DUTY_MODE) begin
				state_d.duty_mode = reg_wdata;
			end else if (bank == BANK_RF && ofs == OFS_EDGE_CTL) begin
				state_d.edge_sel = reg_wdata[0];
			end else if (bank == BANK_RF && ofs == OFS_IRQ_MASK) begin
				state_d.irq_mask = reg_wdata[1:0];
			end else if (bank == BANK_RF && ofs == OFS_ALT_CTL) begin
				state_d.alt = reg_wdata[2:0];
			end
		end
		// Reads.
		state_d.rdata = 4'h0;
		if (reg_rd) begin
			if (bank == BANK_1 && ofs == OFS_LATCH_70) begin
				state_d.rdata = state_q.hv_lat;
			end else if (bank == BANK_0 && ofs == OFS_LATCH_71) begin
				state_d.rdata = (b_s & ~state_q.b_dir) | (state_q.b_lat & state_q.b_dir);
			end else if (bank == BANK_0 && ofs == OFS_LATCH_70) begin
				state_d.rdata = (a_s & ~state_q.a_dir) | (state_q.a_lat & state_q.a_dir);
			end else if (bank == BANK_2 && ofs == OFS_LATCH_71) begin
				state_d.rdata = state_q.odb_lat;
			end else if (bank == BANK_2 && ofs == OFS_LATCH_72) begin
				state_d.rdata = state_q.odc_lat;
			end else if (bank == BANK_0 && ofs == OFS_LATCH_72) begin
				state_d.rdata = state_q.pc_lat;
			end else if (bank == BANK_1 && ofs == OFS_LATCH_72) begin
				state_d.rdata = state_q.grp_dir ? state_q.an_lat : an_s;
			end else if (bank == BANK_0 && ofs == OFS_LATCH_73) begin
				state_d.rdata = d_s;
			end else if (bank == BANK_RF && ofs == OFS_B_DIR) begin
				state_d.rdata = state_q.b_dir;
			end else if (bank == BANK_RF && ofs == OFS_A_DIR) begin
				state_d.rdata = state_q.a_dir;
			end else if (bank == BANK_RF && ofs == OFS_GROUP_DIR) begin
				state_d.rdata = {3'h0, state_q.grp_dir};
			end else if (bank == BANK_RF && ofs == OFS_SYNTH_CTL) begin
				state_d.rdata = {2'h0, state_q.synth_ctl};
			end else if (bank == BANK_RF && ofs == OFS_DUTY_MODE) begin
				state_d.rdata = state_q.duty_mode;
			end else if (bank == BANK_RF && ofs == OFS_EDGE_CTL) begin
				state_d.rdata = {3'h0, state_q.edge_sel};
			end else if (bank == BANK_RF && ofs == OFS_IRQ_STAT) begin
				state_d.rdata = {2'h0, state_q.irq_stat};
			end else if (bank == BANK_RF && ofs == OFS_IRQ_MASK) begin
				state_d.rdata = {2'h0, state_q.irq_mask};
			end else if (bank == BANK_RF && ofs == OFS_ALT_CTL) begin
				state_d.rdata = {1'h0, state_q.alt};
			end
		end
		// Duty pulse timebase: 64 ticks make one 15.625 kHz period.
		if (state_q.tick_cnt == TICK_LAST) begin
			state_d.tick_cnt = 8'h0;
			state_d.phase    = state_q.phase + 6'h1;
		end else begin
			state_d.tick_cnt = state_q.tick_cnt + 8'h1;
		end
		// Synth DAC: a 9-bit PWM frame, stretched one count by the rate multiplier.
		state_d.pwm_cnt = state_q.pwm_cnt + 9'h1;
		if (state_q.pwm_cnt == '1) begin
			state_d.rmp_cnt = state_q.rmp_cnt + 5'h1;
		end
		rmp_add = 1'b0;
		for (int k = 0; k < SYNTH_RMP_W; k++) begin
			if (state_q.synth_val[SYNTH_RMP_W-1-k] && state_q.rmp_cnt[k]
			    && (state_q.rmp_cnt & ((5'h1 << k) - 5'h1)) == 5'h0) begin
				rmp_add = 1'b1;
			end
		end
		pwm_hi = ({1'b0, state_q.pwm_cnt} < ({1'b0, state_q.synth_val[13:5]}
			 + {9'h0, rmp_add}));
		if (state_q.synth_ctl[SYNTH_DAC_EN]) begin
			state_d.synth_oe = ~pwm_hi;
		end else begin
			state_d.synth_oe = ~state_q.synth_ctl[SYNTH_PORT_BIT];
		end
		for (int c = 0; c < 4; c++) begin
			if (state_q.duty_mode[c]) begin
				state_d.duty_oe[c] = ~(state_q.phase < state_q.duty_val[c]);
			end else begin
				state_d.duty_oe[c] = ~state_q.duty_val[c][0];
			end
		end
		// Pins: a direction bit of one drives the latch value.
		state_d.a_out = state_q.a_lat;
		state_d.a_oe  = state_q.a_dir;
		if (state_q.alt[ALT_SERIAL3]) begin
			state_d.a_out[3] = serial_data_out;
			state_d.a_oe[3]  = 1'b1;
			state_d.a_out[2] = serial_clock_out;
			state_d.a_oe[2]  = serial_clock_oe;
		end
		if (state_q.alt[ALT_SERIAL2]) begin
			state_d.a_out[1:0] = 2'h0;
			state_d.a_oe[1:0]  = {twowire_clock_low, twowire_data_low};
		end
		state_d.b_out = state_q.b_lat;
		state_d.b_oe  = state_q.b_dir;
		if (state_q.alt[ALT_LINECNT]) begin
			state_d.b_oe[3] = 1'b0;
		end
		state_d.an_oe  = {4{state_q.grp_dir}};
		state_d.hv_oe  = ~state_q.hv_lat;
		state_d.odb_oe = ~state_q.odb_lat;
		state_d.odc_oe = ~state_q.odc_lat;
		state_d.sdi    = b_s[0];
		state_d.hsc    = b_s[3] & state_q.alt[ALT_LINECNT];
		state_d.tw_d   = a_s[0];
		state_d.tw_c   = a_s[1];
		// Events.
		state_d.rem_prev = rem_s[0];
		state_d.hs_prev  = state_d.hsc;
		rem_edge = state_q.edge_sel ? (state_q.rem_prev & ~rem_s[0])
				: (~state_q.rem_prev & rem_s[0]);
		hs_edge  = state_d.hsc & ~state_q.hs_prev;
		ev       = {hs_edge, rem_edge};
		if (reg_wr && bank == BANK_RF && ofs == OFS_IRQ_STAT) begin
			state_d.irq_stat = state_q.irq_stat & ~reg_wdata[1:0];
		end
		state_d.irq_stat = state_d.irq_stat | ev;
		state_d.irq      = |(state_d.irq_stat & state_d.irq_mask);
		// Chip-enable reset acts like power-on for directions and the edge flag.
		if (ce_rst) begin
			state_d.edge_sel = 1'b0;
			state_d.b_dir    = RST_DIR;
			state_d.b_oe     = RST_DIR;
			state_d.a_dir    = RST_DIR;
			state_d.a_oe     = RST_DIR;
			state_d.grp_dir  = 1'b0;
			state_d.an_oe    = RST_DIR;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_q           <= '0;
			state_q.hv_lat    <= RST_OD_LATCH;
			state_q.odb_lat   <= RST_OD_LATCH;
			state_q.odc_lat   <= RST_OD_LATCH;
			state_q.pc_lat    <= RST_NIBBLE;
			state_q.synth_oe  <= 1'b1;
			state_q.duty_oe   <= 4'hF;
			state_q.duty_val  <= '1;
		end else if (clk_en) begin
			state_q <= state_d;
		end else begin
			state_q.synth_oe <= 1'b1;
		end
	end

	// ****************************************
	// Outputs.
	// ****************************************
	assign reg_rdata                    = state_q.rdata;
	assign bidir_nibble_a_out           = state_q.a_out;
	assign bidir_nibble_a_oe            = state_q.a_oe;
	assign bidir_nibble_b_out           = state_q.b_out;
	assign bidir_nibble_b_oe            = state_q.b_oe;
	assign analog_shared_nibble_out     = state_q.an_lat;
	assign analog_shared_nibble_oe      = state_q.an_oe;
	assign heavy_drive_output_nibble_oe = state_q.hv_oe;
	assign opendrain_nibble_b_oe        = state_q.odb_oe;
	assign opendrain_nibble_c_oe        = state_q.odc_oe;
	assign pushpull_nibble_c_out        = state_q.pc_lat;
	assign synth_dac_output_oe          = state_q.synth_oe;
	assign variable_duty_port_oe        = state_q.duty_oe;
	assign serial_data_in               = state_q.sdi;
	assign twowire_data_in              = state_q.tw_d;
	assign twowire_clock_in             = state_q.tw_c;
	assign line_count_input             = state_q.hsc;
	assign irq                          = state_q.irq;
endmodule // nbp_port

//--- verification/nbp_board.sv
`timescale 1ns/1ps
// ****************************************
// Board side of the three two-way nibbles.
// ****************************************
module nbp_board (
	input  wire logic [3:0] po  [3],
	input  wire logic [3:0] pe  [3],
	input  wire logic [3:0] ext [3],
	output logic      [3:0] pin [3]
);
	// A driven bit shows the port's value and a released bit shows what the board drives.
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			pin[i] = (pe[i] & po[i]) | (~pe[i] & ext[i]);
		end
	end
endmodule // nbp_board

//--- verification/nbp_port_asserts.sv
`timescale 1ns/1ps
// ****************************************
// Latch, direction and reset relations at the pins.
// ****************************************
module nbp_port_asserts
	import nbp_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       clk_en,
	input  wire logic       sys_rst,
	input  wire logic       ce_rst,
	input  wire logic [8:0] reg_addr,
	input  wire logic [3:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic [3:0] bidir_nibble_a_oe,
	input  wire logic [3:0] bidir_nibble_b_out,
	input  wire logic [3:0] bidir_nibble_b_oe,
	input  wire logic [3:0] analog_shared_nibble_oe,
	input  wire logic [3:0] heavy_drive_output_nibble_oe,
	input  wire logic [3:0] opendrain_nibble_b_oe,
	input  wire logic [3:0] opendrain_nibble_c_oe,
	input  wire logic [3:0] pushpull_nibble_c_out,
	input  wire logic       synth_dac_output_oe
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	logic wr_ok;
	assign wr_ok = reg_wr && clk_en && !ce_rst;
	property p_reset_pins;
		$fell(sys_rst) |-> {bidir_nibble_a_oe, bidir_nibble_b_oe, analog_shared_nibble_oe} == 12'h000
			&& synth_dac_output_oe;
	endproperty
	a_reset_pins: assert property (p_reset_pins) else $error("Pins not reset.");
	property p_ce_inputs;
		ce_rst && clk_en |=>
			{bidir_nibble_a_oe, bidir_nibble_b_oe, analog_shared_nibble_oe} == 12'h000;
	endproperty
	a_ce_inputs: assert property (p_ce_inputs) else $error("Pins not input.");
	// Heavy and open-drain latch words reach the pins two edges after the write: latch, then output register; push-pull C takes one edge.
	property p_heavy;
		wr_ok && reg_addr == {BANK_1, OFS_LATCH_70} |-> ##2
			heavy_drive_output_nibble_oe == ~$past(reg_wdata, 2);
	endproperty
	a_heavy: assert property (p_heavy) else $error("Heavy nibble wrong.");
	property p_odb;
		wr_ok && reg_addr == {BANK_2, OFS_LATCH_71} |-> ##2
			opendrain_nibble_b_oe == ~$past(reg_wdata, 2);
	endproperty
	a_odb: assert property (p_odb) else $error("Open-drain B wrong.");
	property p_odc;
		wr_ok && reg_addr == {BANK_2, OFS_LATCH_72} |-> ##2
			opendrain_nibble_c_oe == ~$past(reg_wdata, 2);
	endproperty
	a_odc: assert property (p_odc) else $error("Open-drain C wrong.");
	property p_push;
		wr_ok && reg_addr == {BANK_0, OFS_LATCH_72} |=> pushpull_nibble_c_out == $past(reg_wdata);
	endproperty
	a_push: assert property (p_push) else $error("Push-pull C wrong.");
	property p_b_dir;
		wr_ok && reg_addr == {BANK_RF, OFS_B_DIR} |-> ##2
			bidir_nibble_b_oe == $past(reg_wdata, 2);
	endproperty
	a_b_dir: assert property (p_b_dir) else $error("Port B direction wrong.");
	property p_b_latch;
		wr_ok && reg_addr == {BANK_0, OFS_LATCH_71} |-> ##2
			(bidir_nibble_b_out & bidir_nibble_b_oe) == ($past(reg_wdata, 2) & bidir_nibble_b_oe);
	endproperty
	a_b_latch: assert property (p_b_latch) else $error("Port B latch wrong.");
	property p_group;
		wr_ok && reg_addr == {BANK_RF, OFS_GROUP_DIR} |-> ##2
			analog_shared_nibble_oe == {4{$past(reg_wdata[0], 2)}};
	endproperty
	a_group: assert property (p_group) else $error("Group direction wrong.");
	property p_stop_low;
		!clk_en ##1 !clk_en |-> synth_dac_output_oe;
	endproperty
	a_stop_low: assert property (p_stop_low) else $error("Synth pin not low.");
endmodule // nbp_port_asserts

//--- verification/nbp_port_tb.sv
`timescale 1ns/1ps
module nbp_port_tb;
	import nbp_pkg::*;
	logic       clk, clk_en, sys_rst, ce_rst, reg_wr, reg_rd, remote;
	logic [8:0] reg_addr;
	logic [3:0] reg_wdata, ext_d, d, m;
	logic [4:0] ser;
	logic [3:0] ext [3];
	wire  [3:0] po [3], pe [3], pin [3];
	wire  [3:0] reg_rdata, heavy_oe, odb_oe, odc_oe, pp_out, duty_oe;
	wire        synth_oe, sdi, twdi, twci, lci, irq;
	int         mismatches = 0, checked = 0, cyc = 0, seed, n;
	nbp_port u_dut (
		.clk(clk), .clk_en(clk_en), .sys_rst(sys_rst), .ce_rst(ce_rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.bidir_nibble_a_in(pin[0]), .bidir_nibble_a_out(po[0]), .bidir_nibble_a_oe(pe[0]),
		.bidir_nibble_b_in(pin[1]), .bidir_nibble_b_out(po[1]), .bidir_nibble_b_oe(pe[1]),
		.analog_shared_nibble_in(pin[2]), .analog_shared_nibble_out(po[2]),
		.analog_shared_nibble_oe(pe[2]), .input_nibble_d_in(ext_d),
		.heavy_drive_output_nibble_oe(heavy_oe), .opendrain_nibble_b_oe(odb_oe),
		.opendrain_nibble_c_oe(odc_oe), .pushpull_nibble_c_out(pp_out),
		.synth_dac_output_oe(synth_oe), .variable_duty_port_oe(duty_oe),
		.remote_event_input(remote), .serial_data_out(ser[0]), .serial_clock_out(ser[1]),
		.serial_clock_oe(ser[2]), .twowire_data_low(ser[3]), .twowire_clock_low(ser[4]),
		.serial_data_in(sdi), .twowire_data_in(twdi), .twowire_clock_in(twci),
		.line_count_input(lci), .irq(irq)
	);
	nbp_board u_board (.po(po), .pe(pe), .ext(ext), .pin(pin));
	// ****************************************
	// Clock, timeout and shared tasks.
	// ****************************************
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			mismatches++;
			finish_test();
		end
	end
	task automatic finish_test();
		$display("Comparisons %0d, mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [8:0] a, input logic [3:0] v);
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= v;
		@(posedge clk);
		reg_wr <= 1'b0;
		// Registered pin outputs follow the latch one edge after the write is taken; push-pull C and the analog nibble out are the latch itself.
		@(posedge clk);
		#1;
	endtask
	task automatic rc(input logic [8:0] a, input logic [3:0] exp);
		@(posedge clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask
	task automatic settle();
		repeat (6) @(posedge clk);
		#1;
	endtask
	task automatic remote_pulse(input logic after_rise, input logic after_fall);
		@(posedge clk);
		remote <= 1'b1;
		settle();
		chk(irq, after_rise);
		@(posedge clk);
		remote <= 1'b0;
		settle();
		chk(irq, after_fall);
	endtask
	// ****************************************
	// Main sequence.
	// ****************************************
	initial begin
		sys_rst   = 1'b1;
		clk_en    = 1'b1;
		ce_rst    = 1'b0;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		reg_addr  = 9'h000;
		reg_wdata = 4'h0;
		remote    = 1'b0;
		ser       = 5'h00;
		ext_d     = 4'h0;
		ext       = '{default: 4'h0};
		seed      = 44;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		#1;
		chk({pe[0], pe[1], pe[2], heavy_oe}, 16'h0000);
		chk({odb_oe, odc_oe, 7'h00, synth_oe}, 16'h0001);
		rc({BANK_RF, OFS_B_DIR}, 4'h0);
		rc({BANK_RF, OFS_GROUP_DIR}, 4'h0);
		for (int i = 0; i < 12; i++) begin
			d = 4'($random(seed));
			m = 4'($random(seed));
			wr({BANK_RF, OFS_A_DIR}, 4'hF);
			wr({BANK_0, OFS_LATCH_70}, d);
			chk({pe[0], po[0]}, {4'hF, d});
			wr({BANK_RF, OFS_B_DIR}, m);
			wr({BANK_0, OFS_LATCH_71}, d);
			chk(pe[1], m);
			wr({BANK_1, OFS_LATCH_70}, d);
			wr({BANK_2, OFS_LATCH_71}, ~d);
			wr({BANK_2, OFS_LATCH_72}, m);
			wr({BANK_0, OFS_LATCH_72}, d ^ m);
			chk({heavy_oe, odb_oe, odc_oe, pp_out}, {~d, d, ~m, d ^ m});
			wr({BANK_RF, OFS_GROUP_DIR}, m);
			wr({BANK_1, OFS_LATCH_72}, d);
			chk({pe[2], po[2] & pe[2]}, {{4{m[0]}}, d & {4{m[0]}}});
			@(posedge clk);
			ext[1] <= ~d;
			ext_d  <= m;
			settle();
			rc({BANK_0, OFS_LATCH_71}, (d & m) | (~d & ~m));
			rc({BANK_0, OFS_LATCH_73}, m);
		end
		wr({BANK_RF, OFS_B_DIR}, 4'h0);
		wr({BANK_RF, OFS_ALT_CTL}, 4'h5);
		@(posedge clk);
		ser    <= 5'($random(seed));
		ext[1] <= 4'($random(seed));
		settle();
		chk({sdi, lci, po[0][3:2]}, {ext[1][0], ext[1][3], ser[0], ser[1]});
		wr({BANK_RF, OFS_A_DIR}, 4'h0);
		wr({BANK_RF, OFS_ALT_CTL}, 4'h2);
		@(posedge clk);
		ext[0] <= 4'hF;
		settle();
		chk({twdi, twci}, {~ser[3], ~ser[4]});
		wr({BANK_RF, OFS_ALT_CTL}, 4'h0);
		wr({BANK_RF, OFS_SYNTH_CTL}, 4'h2);
		chk(synth_oe, 1'b0);
		@(posedge clk);
		clk_en <= 1'b0;
		settle();
		chk(synth_oe, 1'b1);
		@(posedge clk);
		clk_en <= 1'b1;
		wr({BANK_RF, OFS_IRQ_MASK}, 4'h1);
		for (int f = 0; f < 2; f++) begin
			wr({BANK_RF, OFS_EDGE_CTL}, 4'(f));
			wr({BANK_RF, OFS_IRQ_STAT}, 4'hF);
			remote_pulse(f == 0, 1'b1);
		end
		wr({BANK_RF, OFS_IRQ_MASK}, 4'h0);
		wr({BANK_RF, OFS_IRQ_STAT}, 4'hF);
		remote_pulse(1'b0, 1'b0);
		wr({BANK_RF, OFS_IRQ_MASK}, 4'h1);
		settle();
		chk(irq, 1'b1);
		wr({BANK_RF, OFS_IRQ_STAT}, 4'h1);
		settle();
		chk(irq, 1'b0);
		wr({BANK_RF, OFS_A_DIR}, 4'hF);
		wr({BANK_RF, OFS_B_DIR}, 4'hF);
		wr({BANK_RF, OFS_GROUP_DIR}, 4'h1);
		@(posedge clk);
		ce_rst <= 1'b1;
		@(posedge clk);
		ce_rst <= 1'b0;
		#1;
		chk({pe[0], pe[1], pe[2]}, 12'h000);
		rc({BANK_RF, OFS_EDGE_CTL}, 4'h0);
		remote_pulse(1'b1, 1'b1);
		wr({BANK_RF, 7'h7F}, 4'hF);
		rc({BANK_RF, 7'h7F}, 4'h0);
		wr({BANK_RF, OFS_DUTY_BASE}, 4'h0);
		wr({BANK_RF, OFS_DUTY_BASE + 7'h01}, 4'h1);
		wr({BANK_RF, OFS_DUTY_MODE}, 4'h1);
		repeat (DUTY_STEPS * DUTY_TICK_CYC) @(posedge clk);
		n = 0;
		repeat (DUTY_STEPS * DUTY_TICK_CYC) begin
			@(posedge clk);
			n += int'(duty_oe[0] === 1'b0);
		end
		chk(n[15:0], 16'(16 * DUTY_TICK_CYC));
		// Over one full rate-multiplier cycle the high time equals the 14-bit value.
		wr({BANK_RF, OFS_SYNTH_LO}, d);
		wr({BANK_RF, OFS_SYNTH_MID}, m);
		wr({BANK_RF, OFS_SYNTH_HI}, 4'h3);
		wr({BANK_RF, OFS_SYNTH_CTL}, 4'h1);
		n = 0;
		repeat (16384) begin
			@(posedge clk);
			n += int'(synth_oe === 1'b0);
		end
		chk(n[15:0], {4'h3, 4'h0, m, d});
		finish_test();
	end
endmodule // nbp_port_tb
bind nbp_port nbp_port_asserts u_chk (
	.clk(clk), .clk_en(clk_en), .sys_rst(sys_rst), .ce_rst(ce_rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .bidir_nibble_a_oe(bidir_nibble_a_oe),
	.bidir_nibble_b_out(bidir_nibble_b_out), .bidir_nibble_b_oe(bidir_nibble_b_oe),
	.analog_shared_nibble_oe(analog_shared_nibble_oe),
	.heavy_drive_output_nibble_oe(heavy_drive_output_nibble_oe),
	.opendrain_nibble_b_oe(opendrain_nibble_b_oe), .opendrain_nibble_c_oe(opendrain_nibble_c_oe),
	.pushpull_nibble_c_out(pushpull_nibble_c_out), .synth_dac_output_oe(synth_dac_output_oe)
);
